// ---- shared/crs_defs.svh ----
// Operation
// - Address-aligned payload starts in the beat after the last descriptor byte.
// - Address-aligned first payload byte sits on the lane given by its address.
// - Keep bits stay high over the gap between descriptor and payload.
// - First payload lane is visible from address bits and byte-valid sideband.
// - Byte-valid ones of one- or two-Dword writes need not be contiguous.
// - Zero-length write carries one payload Dword with all byte-valid bits zero.
// - A memory read packet carries only the 16-byte descriptor.
// - Read packet takes two beats at 64 bits, one beat at 128 or 256.
// - Valid stays high from first to last beat of a packet.
// - While ready is low the current beat and sideband stay stable.
// - First-beat flag is set in the beat carrying the first descriptor byte.
// - Read byte masks are driven valid in the first beat; user derives range.
// - Read masks are contiguous for reads longer than two Dwords.
// - Zero-length read shows Dword count one and both masks zero.
// - An I/O write carries the descriptor and exactly one payload Dword.
// - I/O write payload placement follows the selected alignment mode.
// - I/O write bytes are marked by leading mask and byte-valid bits.
// - An I/O read is descriptor only, one Dword, leading mask marks bytes.
// - Alignment select picks Dword or address placement; lane is address mod width.
// - Keep is contiguous; zeros only in the final beat, which carries last.
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH

// Register byte offsets
`define CRS_REG_CTRL        12'h000
`define CRS_REG_STATUS      12'h004
`define CRS_REG_COUNT       12'h008
// Control fields and reset value
`define CRS_CTRL_ALIGN_BIT  0
`define CRS_CTRL_RESET      1'b0
// Request type codes
`define CRS_TYPE_MRD        4'h0
`define CRS_TYPE_MWR        4'h1
`define CRS_TYPE_IORD       4'h2
`define CRS_TYPE_IOWR       4'h3
// Sideband field positions
`define CRS_SB_LEAD_LSB     0
`define CRS_SB_TRAIL_LSB    4
`define CRS_SB_BV_LSB       8
`define CRS_SB_FIRST_BIT    40
`define CRS_SB_WIDTH        41
// Descriptor length in Dwords
`define CRS_DESC_DW         4

`endif

// ---- shared/crs_pkg.sv ----
`default_nettype none
package crs_pkg;

  // Delivery sequencer, Gray along idle -> load -> send
  typedef enum logic [1:0] {
    CRS_IDLE = 2'h0,
    CRS_LOAD = 2'h1,
    CRS_SEND = 2'h3
  } crs_state_t;

  // Register decode result
  typedef enum logic [1:0] {
    CRS_SEL_CTRL   = 2'h0,
    CRS_SEL_STATUS = 2'h1,
    CRS_SEL_COUNT  = 2'h2,
    CRS_SEL_NONE   = 2'h3
  } crs_sel_t;

endpackage : crs_pkg
`default_nettype wire

// ---- hw/crs_request_delivery.sv ----
`include "crs_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module crs_request_delivery #(
  parameter int DATA_WIDTH = 256,
  parameter int MAX_DW     = 256
) (
  // Clock and reset
  input  wire logic                      i_clock,
  input  wire logic                      i_rstn,
  // Request command from the transaction layer
  input  wire logic                      i_cmd_valid,
  output logic                           o_cmd_ready,
  input  wire logic [3:0]                i_cmd_type,
  input  wire logic [127:0]              i_cmd_desc,
  input  wire logic [4:0]                i_cmd_addr,
  input  wire logic [10:0]               i_cmd_dw_count,
  input  wire logic [3:0]                i_cmd_leading_dword_byte_mask,
  input  wire logic [3:0]                i_cmd_trailing_dword_byte_mask,
  // Payload Dwords, in address order
  input  wire logic                      i_pay_valid,
  output logic                           o_pay_ready,
  input  wire logic [31:0]               i_pay_data,
  // Completer request stream
  output logic [DATA_WIDTH-1:0]          o_request_data,
  output logic                           o_request_valid,
  input  wire logic                      i_request_ready,
  output logic [DATA_WIDTH/32-1:0]       o_request_dword_keep,
  output logic                           o_request_last,
  output logic [`CRS_SB_WIDTH-1:0]       o_request_sideband,
  // APB slave
  input  wire logic                      i_psel,
  input  wire logic                      i_penable,
  input  wire logic                      i_pwrite,
  input  wire logic [11:0]               i_paddr,
  input  wire logic [31:0]               i_pwdata,
  output logic [31:0]                    o_prdata,
  output logic                           o_pready,
  output logic                           o_pslverr
);

  localparam int L     = DATA_WIDTH / 32;
  localparam int AW    = $clog2(MAX_DW);
  localparam int SW    = AW + 2;
  localparam int DSLOT = ((`CRS_DESC_DW + L - 1) / L) * L;
  // Lanes kept in the closing beat of a read
  localparam int RKEEP = `CRS_DESC_DW - ((`CRS_DESC_DW - 1) / L) * L;

  typedef struct packed {
    crs_pkg::crs_state_t     state;
    logic                    cfg_align;
    logic                    pkt_align;
    logic                    cmd_ready;
    logic                    pay_ready;
    logic                    is_read;
    logic [3:0]              ptype;
    logic [SW-1:0]           n;
    logic [SW-1:0]           p0;
    logic [SW-1:0]           total;
    logic [SW-1:0]           nbeats;
    logic [SW-1:0]           beat;
    logic [SW-1:0]           ld;
    logic [127:0]            desc;
    logic [3:0]              fbe;
    logic [3:0]              lbe;
    logic                    ovalid;
    logic [DATA_WIDTH-1:0]   odata;
    logic [L-1:0]            okeep;
    logic                    olast;
    logic [`CRS_SB_WIDTH-1:0] ouser;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
    logic [31:0]             pkt_count;
  } crs_core_t;

  crs_core_t q;
  crs_core_t d;

  logic [31:0] pay_mem [MAX_DW];

  // Register decode, shared by the read and write paths
  function automatic crs_pkg::crs_sel_t reg_sel(input logic [11:0] addr);
    if (addr == `CRS_REG_CTRL) begin
      reg_sel = crs_pkg::CRS_SEL_CTRL;
    end else if (addr == `CRS_REG_STATUS) begin
      reg_sel = crs_pkg::CRS_SEL_STATUS;
    end else if (addr == `CRS_REG_COUNT) begin
      reg_sel = crs_pkg::CRS_SEL_COUNT;
    end else begin
      reg_sel = crs_pkg::CRS_SEL_NONE;
    end
  endfunction : reg_sel

  // Payload store; whole packet is held so beats never starve mid-packet
  always_ff @(posedge i_clock) begin
    if (q.state == crs_pkg::CRS_LOAD && i_pay_valid && q.pay_ready) begin
      pay_mem[q.ld[AW-1:0]] <= i_pay_data;
    end
  end

  // Lane builder: one Dword slot per lane, slot = beat * L + lane
  wire [DATA_WIDTH-1:0] lane_data;
  wire [L-1:0]          lane_keep;
  wire [31:0]           lane_bv;
  wire [31:0]           keep_bytes;
  for (genvar k = 0; k < L; k++) begin : g_lane
    logic [SW-1:0] slot;
    logic [SW-1:0] idx;
    logic          in_pay;
    assign slot   = SW'(q.beat * L + k);
    assign idx    = slot - q.p0;
    assign in_pay = (slot >= q.p0) && (slot < q.total);
    // Gap slots below p0 are still kept: keep runs to the last Dword
    assign lane_keep[k] = slot < q.total;
    assign lane_data[k*32 +: 32] = (slot < SW'(`CRS_DESC_DW)) ?
                                   q.desc[{slot[1:0], 5'h00} +: 32] :
                                   (in_pay ? pay_mem[idx[AW-1:0]] : 32'h0000_0000);
    // Byte-valid per payload Dword, masks passed through as given
    assign lane_bv[k*4 +: 4] = !in_pay ? 4'h0 :
                               (idx == '0) ? q.fbe :
                               (idx == q.n - SW'(1)) ? q.lbe : 4'hF;
    assign keep_bytes[k*4 +: 4] = {4{q.okeep[k]}};
  end
  if (L < 8) begin : g_pad
    assign lane_bv[31:L*4]    = '0;
    assign keep_bytes[31:L*4] = '0;
  end

  // Next-state logic: APB slave and delivery sequencer
  always_comb begin
    logic          zero;
    logic          has_pay;
    logic [SW-1:0] dwoff;
    zero    = 1'b0;
    has_pay = 1'b0;
    dwoff   = '0;
    d       = q;

    // APB: answer one cycle into the access phase
    d.pready  = 1'b0;
    d.pslverr = 1'b0;
    d.prdata  = 32'h0000_0000;
    if (i_psel && i_penable && !q.pready) begin
      d.pready = 1'b1;
      if (i_pwrite) begin
        if (reg_sel(i_paddr) == crs_pkg::CRS_SEL_CTRL) begin
          d.cfg_align = i_pwdata[`CRS_CTRL_ALIGN_BIT];
        end else if (reg_sel(i_paddr) == crs_pkg::CRS_SEL_NONE) begin
          d.pslverr = 1'b1;
        end
      end else begin
        case (reg_sel(i_paddr))
          crs_pkg::CRS_SEL_CTRL:   d.prdata = {31'h0000_0000, q.cfg_align};
          crs_pkg::CRS_SEL_STATUS: d.prdata = {28'h000_0000, q.pkt_align, q.state,
                                               q.state != crs_pkg::CRS_IDLE};
          crs_pkg::CRS_SEL_COUNT:  d.prdata = q.pkt_count;
          default:                 d.pslverr = 1'b1;
        endcase
      end
    end

    case (q.state)
      crs_pkg::CRS_IDLE: begin
        if (i_cmd_valid && q.cmd_ready) begin
          zero      = i_cmd_dw_count == 11'h000;
          has_pay   = i_cmd_type == `CRS_TYPE_MWR || i_cmd_type == `CRS_TYPE_IOWR;
          dwoff     = SW'((i_cmd_addr >> 2) & 5'(L - 1));
          d.cmd_ready = 1'b0;
          d.ptype   = i_cmd_type;
          d.desc    = i_cmd_desc;
          // Alignment is latched per packet so a CTRL write cannot split one
          d.pkt_align = q.cfg_align;
          d.is_read = i_cmd_type == `CRS_TYPE_MRD || i_cmd_type == `CRS_TYPE_IORD;
          d.fbe     = zero ? 4'h0 : i_cmd_leading_dword_byte_mask;
          d.lbe     = zero ? 4'h0 : i_cmd_trailing_dword_byte_mask;
          // Reads carry no payload; I/O write and zero-length write carry one
          d.n = !has_pay ? '0 :
                (i_cmd_type == `CRS_TYPE_IOWR || zero) ? SW'(1) :
                SW'(i_cmd_dw_count);
          // Address mode opens a fresh beat at the address lane
          d.p0 = q.cfg_align ? SW'(DSLOT) + dwoff : SW'(`CRS_DESC_DW);
          // Descriptor-only packets end with the descriptor, whatever the address lane
          d.total  = (d.n == '0) ? SW'(`CRS_DESC_DW) : d.p0 + d.n;
          d.nbeats = SW'((32'(d.total) + L - 1) / L);
          d.beat   = '0;
          d.ld     = '0;
          if (has_pay) begin
            d.state     = crs_pkg::CRS_LOAD;
            d.pay_ready = 1'b1;
          end else begin
            d.state = crs_pkg::CRS_SEND;
          end
        end else begin
          d.cmd_ready = 1'b1;
        end
      end
      crs_pkg::CRS_LOAD: begin
        if (i_pay_valid && q.pay_ready) begin
          d.ld = q.ld + SW'(1);
          if (q.ld == q.n - SW'(1)) begin
            d.pay_ready = 1'b0;
            d.state     = crs_pkg::CRS_SEND;
          end
        end
      end
      crs_pkg::CRS_SEND: begin
        // Output stage moves only when empty or handed over
        if (!q.ovalid || i_request_ready) begin
          if (q.beat < q.nbeats) begin
            d.ovalid = 1'b1;
            d.odata  = lane_data;
            d.okeep  = lane_keep;
            d.olast  = q.beat == q.nbeats - SW'(1);
            d.ouser  = {q.beat == '0, lane_bv, q.lbe, q.fbe};
            d.beat   = q.beat + SW'(1);
          end else begin
            d.ovalid    = 1'b0;
            d.olast     = 1'b0;
            d.state     = crs_pkg::CRS_IDLE;
            d.pkt_count = q.pkt_count + 32'h0000_0001;
          end
        end
      end
      default: begin
        d.state = crs_pkg::CRS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      q           <= '0;
      q.cfg_align <= `CRS_CTRL_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign o_cmd_ready          = q.cmd_ready;
  assign o_pay_ready          = q.pay_ready;
  assign o_request_data       = q.odata;
  assign o_request_valid      = q.ovalid;
  assign o_request_dword_keep = q.okeep;
  assign o_request_last       = q.olast;
  assign o_request_sideband   = q.ouser;
  assign o_prdata             = q.prdata;
  assign o_pready             = q.pready;
  assign o_pslverr            = q.pslverr;

  // Stalled beat must not move
  chk_stall_hold: assert property (@(posedge i_clock) disable iff (!i_rstn)
    q.ovalid && !i_request_ready |=> q.ovalid && $stable(q.odata) && $stable(q.okeep)
      && $stable(q.olast) && $stable(q.ouser))
    else $error("beat changed while stalled");

  // No bubble inside a packet
  chk_valid_cont: assert property (@(posedge i_clock) disable iff (!i_rstn)
    q.ovalid && i_request_ready && !q.olast |=> q.ovalid)
    else $error("valid dropped inside packet");

  // First-beat flag only on the opening beat
  chk_first_flag: assert property (@(posedge i_clock) disable iff (!i_rstn)
    q.ovalid && i_request_ready && !q.olast |=> !q.ouser[`CRS_SB_FIRST_BIT])
    else $error("first flag outside first beat");

  // Keep full on every beat but the last
  chk_keep_tail: assert property (@(posedge i_clock) disable iff (!i_rstn)
    q.ovalid && !q.olast |-> &q.okeep)
    else $error("keep zero before last beat");

  // Read packet length per width
  chk_read_beats: assert property (@(posedge i_clock) disable iff (!i_rstn)
    q.ovalid && q.ouser[`CRS_SB_FIRST_BIT] && q.is_read |-> q.olast == (L >= 4))
    else $error("read packet length wrong");

  // Address mode: first beat holds no payload byte
  chk_aligned_gap: assert property (@(posedge i_clock) disable iff (!i_rstn)
    q.ovalid && q.pkt_align && q.ouser[`CRS_SB_FIRST_BIT]
      |-> q.ouser[`CRS_SB_BV_LSB +: 32] == 32'h0000_0000)
    else $error("payload shares beat with descriptor");

  // Byte-valid only inside kept lanes; zero-length write shows none
  chk_bv_kept: assert property (@(posedge i_clock) disable iff (!i_rstn)
    q.ovalid |-> ((q.ouser[`CRS_SB_BV_LSB +: 32] & ~keep_bytes) == 32'h0000_0000)
      && (!(q.olast && q.n == SW'(1) && q.fbe == 4'h0)
          || q.ouser[`CRS_SB_BV_LSB +: 32] == 32'h0000_0000))
    else $error("byte valid outside packet");

  // Packet ends only on the last handshake, then counted
  chk_handshake: assert property (@(posedge i_clock) disable iff (!i_rstn)
    q.ovalid && i_request_ready && q.olast
      |=> !q.ovalid && q.pkt_count == $past(q.pkt_count) + 32'h0000_0001)
    else $error("packet end not taken on handshake");

  // I/O write carries one Dword
  chk_iowr_one: assert property (@(posedge i_clock) disable iff (!i_rstn)
    q.ovalid && q.ptype == `CRS_TYPE_IOWR
      |-> $countones(q.ouser[`CRS_SB_BV_LSB +: 32]) <= 4 && q.total == q.p0 + SW'(1))
    else $error("I/O write payload not one Dword");

  // APB answers exactly one cycle into access
  chk_apb_answer: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_psel && i_penable && !q.pready |=> q.pready ##1 !q.pready)
    else $error("APB answer timing wrong");

  // Keep runs unbroken upward from lane 0
  chk_keep_cont: assert property (@(posedge i_clock) disable iff (!i_rstn)
    q.ovalid |-> (q.okeep & (q.okeep + L'(1))) == '0)
    else $error("keep not contiguous");

  // Reads carry the descriptor only, no byte-valid
  chk_read_nopay: assert property (@(posedge i_clock) disable iff (!i_rstn)
    q.ovalid && q.is_read |-> q.ouser[`CRS_SB_BV_LSB +: 32] == 32'h0000_0000)
    else $error("read packet shows payload bytes");

  // Read ends on the last descriptor Dword, whatever the address
  chk_read_keep: assert property (@(posedge i_clock) disable iff (!i_rstn)
    q.ovalid && q.is_read && q.olast |-> q.okeep == L'((64'h1 << RKEEP) - 64'h1))
    else $error("read packet keep wrong");

  // Address mode: descriptor beat fully kept ahead of the payload
  chk_gap_keep: assert property (@(posedge i_clock) disable iff (!i_rstn)
    q.ovalid && q.pkt_align && q.n != '0 && q.ouser[`CRS_SB_FIRST_BIT] |-> &q.okeep)
    else $error("gap lanes not kept");

  // Whole payload is stored before the first beat goes out
  chk_load_quiet: assert property (@(posedge i_clock) disable iff (!i_rstn)
    q.state == crs_pkg::CRS_LOAD |-> !q.ovalid)
    else $error("beat sent while loading");

  // One packet at a time
  chk_cmd_block: assert property (@(posedge i_clock) disable iff (!i_rstn)
    q.state != crs_pkg::CRS_IDLE |-> !q.cmd_ready)
    else $error("command taken while busy");

  // Refused access answers with zero data
  chk_err_data: assert property (@(posedge i_clock) disable iff (!i_rstn)
    q.pslverr |-> q.pready && q.prdata == 32'h0000_0000)
    else $error("error answer carries data");

  // No answer without an access phase
  chk_apb_quiet: assert property (@(posedge i_clock) disable iff (!i_rstn)
    !(i_psel && i_penable) |=> !q.pready)
    else $error("pready without access");

endmodule : crs_request_delivery
`default_nettype wire

// ---- sim/crs_user_sink.sv ----
`include "crs_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module crs_user_sink #(
  parameter int W = 128
) (
  // Clock and reset
  input  wire logic                     i_clock,
  input  wire logic                     i_rstn,
  // Test control
  input  wire logic                     i_slow,
  input  wire logic                     i_clear,
  // Completer request stream
  input  wire logic [W-1:0]             i_request_data,
  input  wire logic                     i_request_valid,
  output logic                          o_request_ready,
  input  wire logic [W/32-1:0]          i_request_dword_keep,
  input  wire logic                     i_request_last,
  input  wire logic [`CRS_SB_WIDTH-1:0] i_request_sideband,
  // Stream faults seen
  output logic [7:0]                    o_errs
);
  logic [W-1:0]             bd [8];
  logic [W/32-1:0]          bk [8];
  logic                     bl [8];
  logic [`CRS_SB_WIDTH-1:0] bs [8];
  int                       nbeat;
  logic                     in_pkt, held;
  logic [W+W/32+41:0]       snap;
  int                       owed;
  int                       done;

  // Record beats; a stalled beat must come back unchanged
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_request_ready <= 1'b0;
      o_errs <= 8'h00;
      nbeat <= 0;
      in_pkt <= 1'b0;
      held <= 1'b0;
      owed <= 0;
      done <= 0;
    end else begin
      // Slow mode drops ready every other cycle
      o_request_ready <= i_slow ? ~o_request_ready : 1'b1;
      held <= i_request_valid && !o_request_ready;
      snap <= {i_request_data, i_request_dword_keep, i_request_last, i_request_sideband};
      if (held && snap !== {i_request_data, i_request_dword_keep, i_request_last,
                            i_request_sideband}) o_errs <= o_errs + 8'h01;
      if (in_pkt && !i_request_valid) o_errs <= o_errs + 8'h01;
      if (i_request_valid && o_request_ready) begin
        if (nbeat < 8) begin
          bd[nbeat] <= i_request_data;
          bk[nbeat] <= i_request_dword_keep;
          bl[nbeat] <= i_request_last;
          bs[nbeat] <= i_request_sideband;
        end
        nbeat <= nbeat + 1;
        in_pkt <= !i_request_last;
        // Non-posted request owes a completion; the bench puts the type in bits 3:0
        if (i_request_sideband[`CRS_SB_FIRST_BIT] && i_request_data[3:0] != `CRS_TYPE_MWR)
          owed <= owed + 1;
      end
      if (i_clear) nbeat <= 0;
      // Retire one owed completion a cycle; only the count is kept
      if (done < owed) done <= done + 1;
    end
  end
endmodule : crs_user_sink
`default_nettype wire

// ---- sim/crs_request_delivery_tb_top.sv ----
`include "crs_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module crs_request_delivery_tb_top;
  localparam int W = 128;
  logic                     i_clock, i_rstn, cv, cr, pv, pr, rv, rr, rl, slow, clr, e;
  logic                     psel, pen, pwr, prdy, perr;
  logic [3:0]               ty, fb, lb, rk;
  logic [127:0]             desc;
  logic [4:0]               ad;
  logic [10:0]              dc;
  logic [31:0]              pd, pwd, prd, rdv;
  logic [11:0]              pa;
  logic [W-1:0]             rd;
  logic [`CRS_SB_WIDTH-1:0] sb;
  logic [7:0]               serr;
  int                       fails, comparisons, cyc;

  crs_request_delivery #(.DATA_WIDTH(W), .MAX_DW(16)) crs_request_delivery_inst (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_cmd_valid(cv), .o_cmd_ready(cr), .i_cmd_type(ty),
    .i_cmd_desc(desc), .i_cmd_addr(ad), .i_cmd_dw_count(dc), .i_cmd_leading_dword_byte_mask(fb),
    .i_cmd_trailing_dword_byte_mask(lb), .i_pay_valid(pv), .o_pay_ready(pr), .i_pay_data(pd),
    .o_request_data(rd), .o_request_valid(rv), .i_request_ready(rr),
    .o_request_dword_keep(rk), .o_request_last(rl), .o_request_sideband(sb),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
    .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr));
  crs_user_sink #(.W(W)) crs_user_sink_inst (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_slow(slow), .i_clear(clr), .i_request_data(rd),
    .i_request_valid(rv), .o_request_ready(rr), .i_request_dword_keep(rk),
    .i_request_last(rl), .i_request_sideband(sb), .o_errs(serr));

  // 125 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  task automatic check(input logic [127:0] got, input logic [127:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask : check

  // One APB transfer; waits for pready, the slave sets the pace
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic er);
    int g;
    g = 0;
    @(posedge i_clock);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= wd;
    @(posedge i_clock);
    pen <= 1'b1;
    do begin @(posedge i_clock); g++; end while (prdy !== 1'b1 && g < 50);
    check(prdy, 1'b1, "pready");
    r = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  // Send one request and judge every beat from the placement rules
  task automatic pkt(input logic ag, input logic [3:0] t, input logic [4:0] a,
                     input logic [10:0] n0, input logic [3:0] f, input logic [3:0] l);
    int n, st, en, nb, g, k, s;
    logic zl;
    logic [3:0] ke;
    logic [31:0] be;
    zl = (n0 == 11'h000);
    n = (t == `CRS_TYPE_MWR) ? (zl ? 1 : int'(n0)) : (t == `CRS_TYPE_IOWR) ? 1 : 0;
    st = ag ? 4 + int'(a[3:2]) : 4;
    en = (n > 0) ? st + n : 4;
    nb = (en + 3) / 4;
    apb(1'b1, `CRS_REG_CTRL, {31'h0, ag}, rdv, e);
    clr <= 1'b1;
    @(posedge i_clock);
    clr <= 1'b0;
    cv <= 1'b1;
    ty <= t;
    ad <= a;
    dc <= n0;
    fb <= f;
    lb <= l;
    desc <= {96'hD3D3_D3D3_D2D2_D2D2_D1D1_D1D1, 28'hD0D0_D0D, t};
    g = 0;
    do begin @(posedge i_clock); g++; end while (cr !== 1'b1 && g < 100);
    cv <= 1'b0;
    if (n > 0) begin
      k = 0;
      pv <= 1'b1;
      pd <= 32'hA000_0000;
      while (k < n && g < 200) begin
        @(posedge i_clock);
        g++;
        if (pr === 1'b1) begin k++; pd <= 32'hA000_0000 + k; end
      end
      pv <= 1'b0;
    end
    while (crs_user_sink_inst.nbeat < nb && g < 300) begin @(posedge i_clock); g++; end
    do begin @(posedge i_clock); g++; end while (cr !== 1'b1 && g < 300);
    check(crs_user_sink_inst.nbeat, nb, "beats");
    for (int b = 0; b < nb; b++) begin
      be = 32'h0;
      for (k = 0; k < 4; k++) begin
        s = b * 4 + k;
        ke[k] = (s < en);
        if (s >= st && s < en)
          be[k*4 +: 4] = (s == st) ? (zl ? 4'h0 : f) : (s == en - 1) ? l : 4'hF;
        if (s < 4) check(crs_user_sink_inst.bd[b][k*32 +: 32], desc[s*32 +: 32], "desc");
        else if (s >= st && s < en) check(crs_user_sink_inst.bd[b][k*32 +: 32],
          32'hA000_0000 + s - st, "payload");
      end
      check(crs_user_sink_inst.bk[b], ke, "keep");
      check(crs_user_sink_inst.bl[b], b == nb - 1, "last");
      check(crs_user_sink_inst.bs[b][40], b == 0, "first flag");
      check(crs_user_sink_inst.bs[b][39:8], be, "byte valid");
      check(crs_user_sink_inst.bs[b][3:0], zl ? 4'h0 : f, "lead");
      if (n != 1) check(crs_user_sink_inst.bs[b][7:4], zl ? 4'h0 : l, "trail");
    end
  endtask : pkt

  // Control reset value, readback, unmapped address refused
  task automatic t_regs();
    apb(1'b0, `CRS_REG_CTRL, 32'h0, rdv, e);
    check(rdv, 32'h0, "ctrl reset");
    apb(1'b1, `CRS_REG_CTRL, 32'h1, rdv, e);
    apb(1'b0, `CRS_REG_CTRL, 32'h0, rdv, e);
    check(rdv, 32'h1, "ctrl readback");
    apb(1'b0, `CRS_REG_STATUS, 32'h0, rdv, e);
    check(rdv, 32'h0, "status idle");
    apb(1'b0, 12'h00C, 32'h0, rdv, e);
    check({e, rdv}, 33'h1_0000_0000, "unmapped");
  endtask : t_regs

  // Writes, stalled except the zero-length one: Dword mode, address mode spilling, zero length
  task automatic t_writes();
    slow <= 1'b1;
    pkt(1'b0, `CRS_TYPE_MWR, 5'h04, 11'h006, 4'hE, 4'h3);
    pkt(1'b1, `CRS_TYPE_MWR, 5'h1C, 11'h002, 4'h8, 4'h1);
    pkt(1'b1, `CRS_TYPE_MWR, 5'h08, 11'h001, 4'h5, 4'h0);
    slow <= 1'b0;
    pkt(1'b0, `CRS_TYPE_MWR, 5'h00, 11'h000, 4'hF, 4'hF);
  endtask : t_writes

  // Reads: long, zero length; I/O write in both modes, I/O read in Dword mode
  task automatic t_reads_io();
    pkt(1'b0, `CRS_TYPE_MRD, 5'h00, 11'h008, 4'hF, 4'h7);
    pkt(1'b1, `CRS_TYPE_MRD, 5'h0C, 11'h000, 4'hF, 4'hF);
    pkt(1'b0, `CRS_TYPE_IOWR, 5'h0C, 11'h001, 4'h3, 4'h0);
    pkt(1'b1, `CRS_TYPE_IOWR, 5'h0C, 11'h001, 4'h6, 4'h0);
    pkt(1'b0, `CRS_TYPE_IORD, 5'h04, 11'h001, 4'h1, 4'h0);
  endtask : t_reads_io

  task automatic end_sim();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // Reset, then the scenarios, then the packet counter
  initial begin
    {i_rstn, cv, pv, slow, clr, psel, pen, pwr} = '0;
    {ty, fb, lb, desc, ad, dc, pd, pwd, pa} = '0;
    fails = 0;
    comparisons = 0;
    cyc = 0;
    repeat (20) @(posedge i_clock);
    i_rstn <= 1'b1;
    fork
      begin
        t_regs();
        t_writes();
        t_reads_io();
        check(serr, 8'h00, "stream hold");
        apb(1'b0, `CRS_REG_COUNT, 32'h0, rdv, e);
        check(rdv, 32'h0000_0009, "packet count");
        check(crs_user_sink_inst.owed, 5, "completions owed");
        check(crs_user_sink_inst.done, crs_user_sink_inst.owed, "completions back");
      end
      begin
        // Cut a hang short; the run needs under two hundred cycles
        while (cyc < 20000) begin
          @(posedge i_clock);
          cyc++;
        end
        fails++;
        $display("unexpected at %0t: timeout", $time);
      end
    join_any
    end_sim();
  end
endmodule : crs_request_delivery_tb_top
`default_nettype wire
